/* design/flash_ctrl_defs.svh */
// register offsets, field positions, reset values, unlock key and boot vectors
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH

`define FC_OFF_CONTROL 12'h000
`define FC_OFF_ADDRESS 12'h004
`define FC_OFF_DATA 12'h008
`define FC_OFF_COMMAND 12'h00c
`define FC_OFF_LOCK 12'h010
`define FC_OFF_IRQ_STATUS 12'h014
`define FC_OFF_IRQ_MASK 12'h018

`define FC_BIT_BUSY 5
`define FC_BIT_MAP_DIS 4
`define FC_CONTROL_RESET 1'b1
`define FC_UNLOCK_KEY 32'h2ad5334c
`define FC_BOOT_MAPPED 32'h0000_7000
`define FC_BOOT_PLAIN 32'h0000_0000

`define FC_IRQ_DONE 0
`define FC_IRQ_REFUSED 1
`define FC_IRQ_BITS 2

`define FC_ADDR_HI 28
`define FC_ADDR_LO 2
`define FC_AWIDTH 27

`endif

/* design/flash_ctrl_pkg.sv */
// types shared by the flash controller
package flash_ctrl_pkg;
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_READ = 3'h1,
		OP_PROGRAM = 3'h2,
		OP_PAGE_ERASE = 3'h3,
		OP_MASS_ERASE = 3'h6,
		OP_FULL_ERASE = 3'h7
	} op_code_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ISSUE = 3'b010,
		ST_WAIT = 3'b100
	} seq_state_e;
endpackage

/* design/flash_program_erase_controller.sv */
// flash program/erase controller: apb registers, lock and flash sequencer
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`include "flash_ctrl_defs.svh"

module flash_program_erase_controller
(
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// flash array side
	output logic flash_req,
	output logic [2:0] flash_op,
	output logic [`FC_AWIDTH-1:0] flash_addr,
	output logic [31:0] flash_wdata,
	input wire logic flash_ack,
	input wire logic [31:0] flash_rdata,
	// system
	output logic [31:0] boot_address,
	output logic irq
);

	// software-visible register state, sequencer state and bus staging
	logic map_dis_ff;
	logic busy_ff;
	logic [31:0] addr_ff;
	logic [31:0] data_ff;
	logic [2:0] cmd_ff;
	logic permit_ff;
	logic [`FC_IRQ_BITS-1:0] irq_stat_ff;
	logic [`FC_IRQ_BITS-1:0] irq_mask_ff;
	flash_ctrl_pkg::seq_state_e state_ff;
	flash_ctrl_pkg::seq_state_e nxt_state;
	logic acc_ff;
	logic [31:0] nxt_prdata;
	logic nxt_slverr;

	// bus decode and sequencer events
	logic setup;
	logic wr;
	logic start;
	logic refuse;
	logic done_evt;
	logic [`FC_IRQ_BITS-1:0] set_bits;

	// codes 4 and 5 name no operation, so writing them starts nothing
	function automatic logic known_op(input logic [2:0] op);
		case (op)
			flash_ctrl_pkg::OP_READ, flash_ctrl_pkg::OP_PROGRAM,
			flash_ctrl_pkg::OP_PAGE_ERASE, flash_ctrl_pkg::OP_MASS_ERASE,
			flash_ctrl_pkg::OP_FULL_ERASE:
				known_op = 1'b1;
			default:
				known_op = 1'b0;
		endcase
	endfunction

	// unmapped offsets answer with pslverr and zero read data
	function automatic logic mapped(input logic [11:0] a);
		case (a)
			`FC_OFF_CONTROL, `FC_OFF_ADDRESS, `FC_OFF_DATA, `FC_OFF_COMMAND,
			`FC_OFF_LOCK, `FC_OFF_IRQ_STATUS, `FC_OFF_IRQ_MASK:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	endfunction

	// no wait state: pready rises at the edge that opens the access cycle
	assign setup = psel & ~penable;
	// acc_ff marks the access cycle that follows a genuine setup cycle
	assign wr = psel & penable & acc_ff & pwrite;
	// writes to protected registers are dropped while locked; a dropped nonzero command sets the refused status bit
	assign start = wr & permit_ff & (paddr == `FC_OFF_COMMAND)
		& known_op(pwdata[2:0]) & ~busy_ff;
	// a command written while locked never reaches the array
	assign refuse = wr & ~permit_ff & (paddr == `FC_OFF_COMMAND)
		& (pwdata[2:0] != 3'h0);
	assign done_evt = (state_ff == flash_ctrl_pkg::ST_WAIT) & flash_ack;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			acc_ff <= 1'b0;
		else
			acc_ff <= setup;
	end

	// read data is zero outside the access cycle so stale words never leak
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & nxt_slverr;
			prdata <= (setup & ~pwrite) ? nxt_prdata : 32'h0;
		end
	end

	always_comb
	begin
		nxt_prdata = 32'h0;
		nxt_slverr = ~mapped(paddr);
		case (paddr)
			`FC_OFF_CONTROL:
			begin
				nxt_prdata[`FC_BIT_BUSY] = busy_ff;
				nxt_prdata[`FC_BIT_MAP_DIS] = map_dis_ff;
			end
			`FC_OFF_ADDRESS:
				nxt_prdata = addr_ff;
			`FC_OFF_DATA:
				nxt_prdata = data_ff;
			`FC_OFF_COMMAND:
				nxt_prdata = {29'h0, cmd_ff};
			`FC_OFF_LOCK:
				nxt_prdata = {31'h0, permit_ff};
			`FC_OFF_IRQ_STATUS:
				nxt_prdata = {30'h0, irq_stat_ff};
			`FC_OFF_IRQ_MASK:
				nxt_prdata = {30'h0, irq_mask_ff};
			default:
				nxt_prdata = 32'h0;
		endcase
	end

	// only the main key unlocks; the alternate value locks like any other
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			permit_ff <= 1'b0;
		else if (wr && paddr == `FC_OFF_LOCK)
			permit_ff <= (pwdata == `FC_UNLOCK_KEY);
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			map_dis_ff <= `FC_CONTROL_RESET;
		else if (wr && permit_ff && paddr == `FC_OFF_CONTROL)
			map_dis_ff <= pwdata[`FC_BIT_MAP_DIS];
	end

	// registered so the boot vector cannot glitch while control is rewritten
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			boot_address <= `FC_BOOT_PLAIN;
		else
			boot_address <= map_dis_ff ? `FC_BOOT_PLAIN : `FC_BOOT_MAPPED;
	end

	// bits 31:29 and 1:0 are stored but never used toward the array
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			addr_ff <= 32'h0;
		else if (wr && permit_ff && !busy_ff && paddr == `FC_OFF_ADDRESS)
			addr_ff <= pwdata;
	end

	// a finished read wins; busy already blocks a software write then
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			data_ff <= 32'h0;
		else if (done_evt && cmd_ff == flash_ctrl_pkg::OP_READ)
			data_ff <= flash_rdata;
		else if (wr && permit_ff && !busy_ff && paddr == `FC_OFF_DATA)
			data_ff <= pwdata;
	end

	// command field reads back zero once the operation has finished
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			cmd_ff <= 3'h0;
		else if (start)
			cmd_ff <= pwdata[2:0];
		else if (done_evt)
			cmd_ff <= 3'h0;
	end

	// issue state registers op, address and data at the same edge as req
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			flash_ctrl_pkg::ST_IDLE:
				if (start)
					nxt_state = flash_ctrl_pkg::ST_ISSUE;
			flash_ctrl_pkg::ST_ISSUE:
				nxt_state = flash_ctrl_pkg::ST_WAIT;
			flash_ctrl_pkg::ST_WAIT:
				if (flash_ack)
					nxt_state = flash_ctrl_pkg::ST_IDLE;
			default:
				nxt_state = flash_ctrl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			state_ff <= flash_ctrl_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// busy also freezes address, data and command until the array answers
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			busy_ff <= 1'b0;
		else if (start)
			busy_ff <= 1'b1;
		else if (done_evt)
			busy_ff <= 1'b0;
	end

	// request is held from issue until the array acknowledges
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			flash_req <= 1'b0;
			flash_op <= 3'h0;
			flash_addr <= '0;
			flash_wdata <= 32'h0;
		end
		else if (state_ff == flash_ctrl_pkg::ST_ISSUE)
		begin
			flash_req <= 1'b1;
			flash_op <= cmd_ff;
			flash_addr <= addr_ff[`FC_ADDR_HI:`FC_ADDR_LO];
			flash_wdata <= data_ff;
		end
		else if (done_evt)
			flash_req <= 1'b0;
	end

	assign set_bits = {refuse, done_evt};

	// hardware set wins over a write-one clear in the same cycle
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			irq_stat_ff <= '0;
		else if (wr && paddr == `FC_OFF_IRQ_STATUS)
			irq_stat_ff <= (irq_stat_ff & ~pwdata[`FC_IRQ_BITS-1:0]) | set_bits;
		else
			irq_stat_ff <= irq_stat_ff | set_bits;
	end

	// status and mask stay writable while locked, so a refusal can be cleared
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			irq_mask_ff <= '0;
		else if (wr && paddr == `FC_OFF_IRQ_MASK)
			irq_mask_ff <= pwdata[`FC_IRQ_BITS-1:0];
	end

	// level interrupt, one cycle behind the status bits
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_ff & irq_mask_ff);
	end

endmodule // flash_program_erase_controller

/* tb/flash_array_model.sv */
// behavioural flash array behind the controller
`timescale 1ns/1ns
module flash_array_model
(
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// request
	input wire logic flash_req,
	input wire logic [2:0] flash_op,
	input wire logic [26:0] flash_addr,
	input wire logic [31:0] flash_wdata,
	// answer
	output logic flash_ack,
	output logic [31:0] flash_rdata
);
	logic [31:0] mem [16];
	int dly = 2;
	int cnt;
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			flash_ack <= 1'b0;
			flash_rdata <= 32'h0;
			cnt <= 0;
			foreach (mem[i]) mem[i] <= 32'hffffffff;
		end
		else
		begin
			// data only valid with ack
			flash_ack <= 1'b0;
			flash_rdata <= ~flash_rdata;
			cnt <= 0;
			if (flash_req && !flash_ack && cnt < dly)
				cnt <= cnt + 1;
			else if (flash_req && !flash_ack)
			begin
				flash_ack <= 1'b1;
				case (flash_op)
					3'h1: flash_rdata <= mem[flash_addr[3:0]];
					3'h2: mem[flash_addr[3:0]] <= mem[flash_addr[3:0]] & flash_wdata;
					default: foreach (mem[i]) mem[i] <= 32'hffffffff;
				endcase
			end
		end
	end
endmodule // flash_array_model

/* tb/flash_ctrl_chk.sv */
// port assertions for the flash controller
`timescale 1ns/1ns
module flash_ctrl_chk
(
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// flash and system
	input wire logic flash_req,
	input wire logic [2:0] flash_op,
	input wire logic flash_ack,
	input wire logic [31:0] boot_address
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wait;
		flash_req && !flash_ack;
	endsequence
	property p_answer;
		s_setup |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no ready");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_err;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_hold;
		s_wait |=> flash_req;
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_end;
		flash_req && flash_ack |=> !flash_req;
	endproperty
	a_end: assert property (p_end) else $error("request stuck");
	property p_op;
		flash_req |-> flash_op inside {3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	endproperty
	a_op: assert property (p_op) else $error("bad op code");
	property p_stable;
		s_wait |=> $stable(flash_op);
	endproperty
	a_stable: assert property (p_stable) else $error("op changed");
	property p_boot;
		boot_address == 32'h0 || boot_address == 32'h7000;
	endproperty
	a_boot: assert property (p_boot) else $error("bad boot address");
endmodule // flash_ctrl_chk
bind flash_program_erase_controller flash_ctrl_chk chk_i (
	.clock(clock),
	.rstn(rstn),
	.psel(psel),
	.penable(penable),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.flash_req(flash_req),
	.flash_op(flash_op),
	.flash_ack(flash_ack),
	.boot_address(boot_address)
);

/* tb/flash_program_erase_controller_tb.sv */
// register-level bench for the flash controller
`timescale 1ns/1ns
module flash_program_erase_controller_tb;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, flash_wdata, flash_rdata, boot_address;
	logic pready, pslverr, er, flash_req, flash_ack, irq;
	logic [2:0] flash_op;
	logic [26:0] flash_addr;
	logic [2:0] ops [3] = '{3'h3, 3'h6, 3'h7};
	int n_fail = 0;
	int total_checks = 0;
	always #4 clock = ~clock;
	flash_program_erase_controller uut (.*);
	flash_array_model fm (.*);
	task wrap_up;
		if (n_fail == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
		if (n == 20)
		begin
			n_fail++;
			wrap_up;
		end
	endtask
	// poll busy, bounded
	task wt;
		int n;
		n = 0;
		do
		begin
			bus(1'b0, 12'h000, 32'h0);
			n++;
		end while (rd[5] !== 1'b0 && n < 40);
		if (rd[5] !== 1'b0)
		begin
			n_fail++;
			wrap_up;
		end
	endtask
	initial
	begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b0, 12'(i * 4), 32'h0);
			chk("reset value", rd, (i == 0) ? 32'h10 : 32'h0);
		end
		chk("boot", boot_address, 32'h0);
		bus(1'b1, 12'h008, 32'hcafe0001);
		bus(1'b1, 12'h00c, 32'h2);
		bus(1'b0, 12'h008, 32'h0);
		chk("data locked", rd, 32'h0);
		bus(1'b0, 12'h000, 32'h0);
		chk("control locked", rd, 32'h10);
		bus(1'b1, 12'h010, 32'h55aa6699);
		bus(1'b0, 12'h010, 32'h0);
		chk("lock alt", {31'h0, rd[0]}, 32'h0);
		bus(1'b1, 12'h010, 32'h2ad5334c);
		bus(1'b0, 12'h010, 32'h0);
		chk("lock key", {31'h0, rd[0]}, 32'h1);
		bus(1'b1, 12'h014, 32'h3);
		bus(1'b1, 12'h018, 32'h3);
		fm.dly = 6;
		bus(1'b1, 12'h004, 32'h14);
		bus(1'b1, 12'h008, 32'h12345678);
		bus(1'b1, 12'h00c, 32'h2);
		bus(1'b0, 12'h000, 32'h0);
		chk("busy", rd, 32'h30);
		wt();
		chk("irq done", {31'h0, irq}, 32'h1);
		chk("word address", {5'h0, flash_addr}, 32'h5);
		chk("program data", flash_wdata, 32'h12345678);
		chk("op code", {29'h0, flash_op}, 32'h2);
		bus(1'b1, 12'h014, 32'h1);
		// irq trails the status bits by one edge
		@(posedge clock);
		chk("irq clear", {31'h0, irq}, 32'h0);
		fm.dly = 0;
		bus(1'b1, 12'h008, 32'h0);
		bus(1'b1, 12'h00c, 32'h1);
		wt();
		bus(1'b0, 12'h008, 32'h0);
		chk("read back", rd, 32'h12345678);
		foreach (ops[i])
		begin
			bus(1'b1, 12'h008, 32'h0);
			bus(1'b1, 12'h00c, 32'h2);
			wt();
			bus(1'b1, 12'h00c, {29'h0, ops[i]});
			wt();
			bus(1'b1, 12'h00c, 32'h1);
			wt();
			bus(1'b0, 12'h008, 32'h0);
			chk("erased", rd, 32'hffffffff);
		end
		bus(1'b1, 12'h00c, 32'h4);
		bus(1'b0, 12'h000, 32'h0);
		chk("bad code", rd, 32'h10);
		bus(1'b1, 12'h000, 32'h0);
		// boot vector is registered behind the control bit
		@(posedge clock);
		chk("boot mapped", boot_address, 32'h7000);
		bus(1'b1, 12'h000, 32'h10);
		bus(1'b0, 12'h100, 32'h0);
		chk("unmapped", {er, rd[30:0]}, 32'h80000000);
		// earlier completions left the done bit set
		bus(1'b1, 12'h014, 32'h3);
		bus(1'b1, 12'h010, 32'h0);
		bus(1'b1, 12'h00c, 32'h3);
		bus(1'b0, 12'h014, 32'h0);
		chk("refused", rd, 32'h2);
		chk("irq refused", {31'h0, irq}, 32'h1);
		wrap_up;
	end
endmodule // flash_program_erase_controller_tb
